/* File: tesf_pkg.sv */
package tesf_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_SRC_ONE = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_SRC_TWO = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_CFG_ONE = 4'hc;

	// field positions
	localparam int STATUS_OUT_POS = 4;
	localparam int STATUS_WIN_POS = 3;
	localparam int SRC_ACTIVE_POS = 0;
	localparam int CFG_OUT_ELE_POS = 0;
	localparam int CFG_WIN_ELE_POS = 1;

	// event indices
	localparam int NUM_EV = 2;
	localparam int EV_OUT = 0;
	localparam int EV_WIN = 1;

	localparam logic [NUM_EV-1:0] CFG_ELE_RESET = 2'h0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		W_IDLE = 3'b001,
		W_TAKE = 3'b010,
		W_RESP = 3'b100
	} tesf_wr_state_t;

	typedef enum logic [3:0] {
		R_IDLE = 4'b0001,
		R_TAKE = 4'b0010,
		R_LOOK = 4'b0100,
		R_DATA = 4'b1000
	} tesf_rd_state_t;

	function automatic logic tesf_readable(input logic [ADDR_W-1:0] a);
		return (a == OFF_STATUS) || (a == OFF_SRC_ONE) || (a == OFF_SRC_TWO) ||
			(a == OFF_CFG_ONE);
	endfunction

	function automatic logic tesf_writable(input logic [ADDR_W-1:0] a);
		return a == OFF_CFG_ONE;
	endfunction

endpackage

/* File: tesf_regs_if.sv */
`timescale 1ns/10ps
interface tesf_regs_if;
	import tesf_pkg::*;

	logic wr_req;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic [STRB_W-1:0] wr_strb;
	logic rd_req;
	logic [ADDR_W-1:0] rd_addr;
	logic [DATA_W-1:0] rd_data;
	logic [NUM_EV-1:0] flags;
	logic [NUM_EV-1:0] latch_en;
	logic [NUM_EV-1:0] rd_clear;

	modport bus (
		output wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr,
		input rd_data
	);

	modport regs (
		input wr_req, wr_addr, wr_data, wr_strb, rd_req, rd_addr, flags,
		output rd_data, latch_en, rd_clear
	);

endinterface

/* File: tesf_event_flag.sv */
`timescale 1ns/10ps
module tesf_event_flag (
	input logic aclk,
	input logic aresetn,
	input logic cond,
	input logic latch_en,
	input logic rd_clear,
	output logic flag
);

	typedef struct packed {
		logic flag;
	} tesf_flag_state_t;

	tesf_flag_state_t q;
	tesf_flag_state_t next_q;

	always_comb begin
		next_q = q;
		// a live condition always wins over a clearing read
		next_q.flag = cond | (latch_en & q.flag & ~rd_clear);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign flag = q.flag;

endmodule

/* File: tesf_reg_file.sv */
`timescale 1ns/10ps
module tesf_reg_file
	import tesf_pkg::*;
(
	input logic aclk,
	input logic aresetn,
	tesf_regs_if.regs regs
);

	typedef struct packed {
		logic [NUM_EV-1:0] latch_en;
	} tesf_cfg_state_t;

	tesf_cfg_state_t q;
	tesf_cfg_state_t next_q;

	always_comb begin
		next_q = q;
		if (regs.wr_req && regs.wr_addr == OFF_CFG_ONE && regs.wr_strb[0]) begin
			next_q.latch_en[EV_OUT] = regs.wr_data[CFG_OUT_ELE_POS];
			next_q.latch_en[EV_WIN] = regs.wr_data[CFG_WIN_ELE_POS];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= CFG_ELE_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign regs.latch_en = q.latch_en;

	// only the detector's own source registers clear on read
	always_comb begin
		regs.rd_clear = '0;
		regs.rd_clear[EV_OUT] = regs.rd_req && regs.rd_addr == OFF_SRC_ONE;
		regs.rd_clear[EV_WIN] = regs.rd_req && regs.rd_addr == OFF_SRC_TWO;
	end

	always_comb begin
		regs.rd_data = '0;
		unique case (regs.rd_addr)
			OFF_STATUS: begin
				regs.rd_data[STATUS_OUT_POS] = regs.flags[EV_OUT];
				regs.rd_data[STATUS_WIN_POS] = regs.flags[EV_WIN];
			end
			OFF_SRC_ONE: begin
				regs.rd_data[SRC_ACTIVE_POS] = regs.flags[EV_OUT];
			end
			OFF_SRC_TWO: begin
				regs.rd_data[SRC_ACTIVE_POS] = regs.flags[EV_WIN];
			end
			OFF_CFG_ONE: begin
				regs.rd_data[CFG_OUT_ELE_POS] = q.latch_en[EV_OUT];
				regs.rd_data[CFG_WIN_ELE_POS] = q.latch_en[EV_WIN];
			end
			default: begin
				regs.rd_data = '0;
			end
		endcase
	end

endmodule

/* File: tesf_top.sv */
`timescale 1ns/10ps
// How it works
// - status bit 4 mirrors outside-threshold event flag
// - latched outside flag holds until source-one read
// - unlatched outside flag drops when condition ends
// - status bit 3 mirrors within-threshold event flag
// - latched within flag holds until source-two read
// - unlatched within flag drops when condition ends
module tesf_top
	import tesf_pkg::*;
(
	input logic aclk,
	input logic aresetn,
	input logic [ADDR_W-1:0] s_axi_awaddr,
	input logic [2:0] s_axi_awprot,
	input logic s_axi_awvalid,
	output logic s_axi_awready,
	input logic [DATA_W-1:0] s_axi_wdata,
	input logic [STRB_W-1:0] s_axi_wstrb,
	input logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic [ADDR_W-1:0] s_axi_araddr,
	input logic [2:0] s_axi_arprot,
	input logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic outside_event_condition,
	input logic within_event_condition,
	output logic outside_event_status_bit,
	output logic within_event_status_bit
);

	typedef struct packed {
		tesf_wr_state_t wst;
		tesf_rd_state_t rst;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
		logic wr_req;
		logic [ADDR_W-1:0] wr_addr;
		logic [DATA_W-1:0] wr_data;
		logic [STRB_W-1:0] wr_strb;
		logic rd_req;
		logic [ADDR_W-1:0] rd_addr;
	} tesf_axi_state_t;

	localparam tesf_axi_state_t AXI_RESET = '{
		wst: W_IDLE,
		rst: R_IDLE,
		bresp: RESP_OKAY,
		rresp: RESP_OKAY,
		default: '0
	};

	tesf_axi_state_t q;
	tesf_axi_state_t next_q;
	logic [NUM_EV-1:0] cond;
	logic [NUM_EV-1:0] flags;

	tesf_regs_if regs_if ();

	// conditions come from detector logic on aclk, so no synchroniser
	always_comb begin
		cond = '0;
		cond[EV_OUT] = outside_event_condition;
		cond[EV_WIN] = within_event_condition;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EV; gi++) begin : g_flag
			tesf_event_flag u_flag (
				.aclk(aclk),
				.aresetn(aresetn),
				.cond(cond[gi]),
				.latch_en(regs_if.latch_en[gi]),
				.rd_clear(regs_if.rd_clear[gi]),
				.flag(flags[gi])
			);
		end
	endgenerate

	assign regs_if.flags = flags;

	tesf_reg_file u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.regs(regs_if.regs)
	);

	assign regs_if.wr_req = q.wr_req;
	assign regs_if.wr_addr = q.wr_addr;
	assign regs_if.wr_data = q.wr_data;
	assign regs_if.wr_strb = q.wr_strb;
	assign regs_if.rd_req = q.rd_req;
	assign regs_if.rd_addr = q.rd_addr;

	always_comb begin
		next_q = q;
		next_q.wr_req = 1'b0;
		next_q.rd_req = 1'b0;

		// write channel: address and data are taken together in one beat
		unique case (q.wst)
			W_IDLE: begin
				if (s_axi_awvalid && s_axi_wvalid) begin
					next_q.awready = 1'b1;
					next_q.wready = 1'b1;
					next_q.wst = W_TAKE;
				end
			end
			W_TAKE: begin
				next_q.awready = 1'b0;
				next_q.wready = 1'b0;
				next_q.wr_req = tesf_writable(s_axi_awaddr);
				next_q.wr_addr = s_axi_awaddr;
				next_q.wr_data = s_axi_wdata;
				next_q.wr_strb = s_axi_wstrb;
				next_q.bresp = tesf_writable(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
				next_q.bvalid = 1'b1;
				next_q.wst = W_RESP;
			end
			W_RESP: begin
				if (s_axi_bready) begin
					next_q.bvalid = 1'b0;
					next_q.wst = W_IDLE;
				end
			end
			default: begin
				next_q.awready = 1'b0;
				next_q.wready = 1'b0;
				next_q.bvalid = 1'b0;
				next_q.wst = W_IDLE;
			end
		endcase

		// read channel: data is captured in the same edge that clears a flag,
		// so the host always sees the value it cleared
		unique case (q.rst)
			R_IDLE: begin
				if (s_axi_arvalid) begin
					next_q.arready = 1'b1;
					next_q.rst = R_TAKE;
				end
			end
			R_TAKE: begin
				next_q.arready = 1'b0;
				next_q.rd_req = 1'b1;
				next_q.rd_addr = s_axi_araddr;
				next_q.rst = R_LOOK;
			end
			R_LOOK: begin
				next_q.rdata = regs_if.rd_data;
				next_q.rresp = tesf_readable(q.rd_addr) ? RESP_OKAY : RESP_SLVERR;
				next_q.rvalid = 1'b1;
				next_q.rst = R_DATA;
			end
			R_DATA: begin
				if (s_axi_rready) begin
					next_q.rvalid = 1'b0;
					next_q.rst = R_IDLE;
				end
			end
			default: begin
				next_q.arready = 1'b0;
				next_q.rvalid = 1'b0;
				next_q.rst = R_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= AXI_RESET;
		end else begin
			q <= next_q;
		end
	end

	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bresp = q.bresp;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rvalid = q.rvalid;
	assign outside_event_status_bit = flags[EV_OUT];
	assign within_event_status_bit = flags[EV_WIN];

endmodule

/* File: tesf_top_chk.sv */
`timescale 1ns/10ps
module tesf_top_chk (
	input logic aclk,
	input logic aresetn,
	input logic outside_event_condition,
	input logic within_event_condition,
	input logic outside_event_status_bit,
	input logic within_event_status_bit
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_out_set;
		outside_event_condition |=> outside_event_status_bit;
	endproperty
	a_out_set: assert property (p_out_set) else $error("out flag missed");
	property p_out_rise;
		$rose(outside_event_status_bit) |-> $past(outside_event_condition);
	endproperty
	a_out_rise: assert property (p_out_rise) else $error("out flag bogus");
	// a drop while the condition holds is wrong in either latch mode
	property p_out_fall;
		$fell(outside_event_status_bit) |-> !$past(outside_event_condition);
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("out flag drop");
	property p_win_set;
		within_event_condition |=> within_event_status_bit;
	endproperty
	a_win_set: assert property (p_win_set) else $error("win flag missed");
	property p_win_rise;
		$rose(within_event_status_bit) |-> $past(within_event_condition);
	endproperty
	a_win_rise: assert property (p_win_rise) else $error("win flag bogus");
	property p_win_fall;
		$fell(within_event_status_bit) |-> !$past(within_event_condition);
	endproperty
	a_win_fall: assert property (p_win_fall) else $error("win flag drop");
endmodule
bind tesf_top tesf_top_chk u_chk (.aclk(aclk), .aresetn(aresetn),
	.outside_event_condition(outside_event_condition),
	.within_event_condition(within_event_condition),
	.outside_event_status_bit(outside_event_status_bit),
	.within_event_status_bit(within_event_status_bit));

/* File: tesf_top_tb.sv */
`timescale 1ns/10ps
module tesf_top_tb;
	import tesf_pkg::*;
	logic aclk = 1'h0, aresetn = 1'h0, oc = 1'h0, wc = 1'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [ADDR_W-1:0] awaddr = 4'h0, araddr = 4'h0;
	logic [DATA_W-1:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, of, wf;
	logic [1:0] bresp, rresp;
	int err_count = 0, n_compared = 0, cycles = 0;
	tesf_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.outside_event_condition(oc), .within_event_condition(wc),
		.outside_event_status_bit(of), .within_event_status_bit(wf));
	always #25 aclk = ~aclk;
	task automatic complete_run;
		if (err_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			err_count++;
			complete_run();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		bready <= 1'h0;
		chk({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		rready <= 1'h0;
		chk(rdata, ed);
		chk({30'h0, rresp}, {30'h0, er});
	endtask
	// flags sampled mid-cycle so the edge's register updates have landed
	task automatic fl(input logic [1:0] e);
		@(negedge aclk);
		chk({30'h0, of, wf}, {30'h0, e});
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'h1;
		fl(2'h0);
		rd(OFF_CFG_ONE, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		@(posedge aclk);
		oc <= 1'h1;
		wc <= 1'h1;
		@(posedge aclk);
		oc <= 1'h0;
		fl(2'h3);
		@(posedge aclk);
		wc <= 1'h0;
		fl(2'h1);
		fl(2'h0);
		wr(OFF_CFG_ONE, 32'h3, RESP_OKAY);
		rd(OFF_CFG_ONE, 32'h3, RESP_OKAY);
		@(posedge aclk);
		oc <= 1'h1;
		wc <= 1'h1;
		@(posedge aclk);
		oc <= 1'h0;
		wc <= 1'h0;
		repeat (3) fl(2'h3);
		rd(OFF_STATUS, 32'h18, RESP_OKAY);
		rd(OFF_SRC_ONE, 32'h1, RESP_OKAY);
		fl(2'h1);
		@(posedge aclk);
		wc <= 1'h1;
		// a clearing read while the condition still holds must not win
		rd(OFF_SRC_TWO, 32'h1, RESP_OKAY);
		fl(2'h1);
		@(posedge aclk);
		wc <= 1'h0;
		rd(OFF_SRC_TWO, 32'h1, RESP_OKAY);
		fl(2'h0);
		rd(OFF_SRC_TWO, 32'h0, RESP_OKAY);
		rd(OFF_STATUS, 32'h0, RESP_OKAY);
		wr(OFF_STATUS, 32'h18, RESP_SLVERR);
		rd(4'h2, 32'h0, RESP_SLVERR);
		complete_run();
	end
endmodule
